// [design/timer16_cfg.svh]
`ifndef TIMER16_CFG_SVH
`define TIMER16_CFG_SVH

// Register byte offsets on the bus.
`define OFS_CONTROL 8'h00
`define OFS_COUNTER 8'h04
`define OFS_COMPARE_A 8'h08
`define OFS_COMPARE_B 8'h0c
`define OFS_CAPTURE 8'h10
`define OFS_FLAGS 8'h14
`define OFS_FORCE 8'h18

// Waveform mode codes.
`define MODE_NORMAL 4'h0
`define MODE_CTC_A 4'h4
`define MODE_FAST_8 4'h5
`define MODE_FAST_9 4'h6
`define MODE_FAST_10 4'h7
`define MODE_CTC_CAPTURE 4'hc
`define MODE_FAST_CAPTURE 4'he
`define MODE_FAST_A 4'hf

// Output action codes.
`define ACTION_NONE 2'h0
`define ACTION_TOGGLE 2'h1
`define ACTION_CLEAR 2'h2
`define ACTION_SET 2'h3

// Fixed TOP values.
`define TOP_FIXED_8 16'h00ff
`define TOP_FIXED_9 16'h01ff
`define TOP_FIXED_10 16'h03ff

// Flag bit positions.
`define FLAG_OVERFLOW 0
`define FLAG_COMPARE_A 1
`define FLAG_COMPARE_B 2
`define FLAG_CAPTURE 3

// Reset values.
`define RESET_CONTROL 10'h000
`define RESET_VALUE 16'h0000

`endif

// [design/timer16_normal_ctc_fast_pwm.sv]
`timescale 1ns/1ps
`include "timer16_cfg.svh"

module timer16_normal_ctc_fast_pwm #(
  parameter int WIDTH = 16
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic timerTick,
  output logic compareAPin,
  output logic compareAEnable,
  output logic compareBPin,
  output logic compareBEnable
);

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Helper functions.

  function automatic timer16_pkg::count_kind_t kindOf(input logic [3:0] mode);
    case (mode)
      `MODE_CTC_A, `MODE_CTC_CAPTURE: kindOf = timer16_pkg::KIND_CTC;
      `MODE_FAST_8, `MODE_FAST_9, `MODE_FAST_10,
      `MODE_FAST_CAPTURE, `MODE_FAST_A: kindOf = timer16_pkg::KIND_FAST;
      default: kindOf = timer16_pkg::KIND_NORMAL;
    endcase
  endfunction : kindOf

  function automatic logic [WIDTH-1:0] fixedMask(input logic [3:0] mode);
    case (mode)
      `MODE_FAST_8: fixedMask = WIDTH'(`TOP_FIXED_8);
      `MODE_FAST_9: fixedMask = WIDTH'(`TOP_FIXED_9);
      `MODE_FAST_10: fixedMask = WIDTH'(`TOP_FIXED_10);
      default: fixedMask = '1;
    endcase
  endfunction : fixedMask

  function automatic logic [WIDTH-1:0] mergeBytes(input logic [WIDTH-1:0] old,
                                                  input logic [31:0] data,
                                                  input logic [3:0] sel);
    logic [WIDTH-1:0] result;
    result = old;
    for (int b = 0; b < WIDTH / 8; b++) begin
      if (sel[b]) begin
        result[b*8 +: 8] = data[b*8 +: 8];
      end
    end
    mergeBytes = result;
  endfunction : mergeBytes

  // Decodes a register write to one offset.
  function automatic logic writeTo(input logic write,
                                   input logic [7:0] address,
                                   input logic [7:0] target);
    writeTo = write && (address == target);
  endfunction : writeTo

  // A match needs a tick, no blocking write and a compare value within TOP.
  function automatic logic compareHit(input logic tick,
                                      input logic blocked,
                                      input logic [WIDTH-1:0] count,
                                      input logic [WIDTH-1:0] value,
                                      input logic [WIDTH-1:0] limit);
    logic hit;
    hit = tick && !blocked && (count == value);
    if (value > limit) begin
      hit = 1'b0;
    end
    compareHit = hit;
  endfunction : compareHit

  ////////////////////////////////////////////////////////////////////////////////////////////
  // State.

  timer16_pkg::control_t control;
  timer16_pkg::flags_t flags;
  logic [WIDTH-1:0] counter;
  logic [WIDTH-1:0] capture;
  logic [WIDTH-1:0] compareBuf [2];
  logic [WIDTH-1:0] compareActive [2];
  logic [1:0] level;
  logic blockMatch;

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Decode and compare.

  timer16_pkg::count_kind_t kind;
  logic [WIDTH-1:0] top;
  logic [WIDTH-1:0] maskedCompare [2];
  logic [WIDTH-1:0] next_counter;
  logic busWrite;
  logic writeCounter;
  logic topHit;
  logic wrapMax;
  logic topIsCapture;
  logic topIsCompareA;
  logic [1:0] match;
  logic [1:0] writeCompare;
  logic [1:0] forceHit;

  assign kind = kindOf(control.mode);
  assign topIsCapture = (control.mode == `MODE_CTC_CAPTURE) || (control.mode == `MODE_FAST_CAPTURE);
  assign topIsCompareA = (control.mode == `MODE_CTC_A) || (control.mode == `MODE_FAST_A);
  assign busWrite = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
  assign writeCounter = writeTo(busWrite, wb_adr_i, `OFS_COUNTER);
  assign writeCompare[0] = writeTo(busWrite, wb_adr_i, `OFS_COMPARE_A);
  assign writeCompare[1] = writeTo(busWrite, wb_adr_i, `OFS_COMPARE_B);

  always_comb begin
    if (topIsCapture) begin
      top = capture;
    end else if (topIsCompareA) begin
      top = compareActive[0];
    end else begin
      top = fixedMask(control.mode);
    end
  end

  assign wrapMax = timerTick && (counter == '1);
  // TOP is seen only on a tick that is not blocked by a counter write.
  assign topHit = timerTick && !blockMatch && (kind != timer16_pkg::KIND_NORMAL)
                  && (counter == top);
  assign match[0] = compareHit(timerTick, blockMatch, counter, compareActive[0], top);
  assign match[1] = compareHit(timerTick, blockMatch, counter, compareActive[1], top);
  assign maskedCompare[0] = mergeBytes(compareBuf[0], wb_dat_i, wb_sel_i)
                            & fixedMask(control.mode);
  assign maskedCompare[1] = mergeBytes(compareBuf[1], wb_dat_i, wb_sel_i)
                            & fixedMask(control.mode);
  assign forceHit[0] = writeTo(busWrite, wb_adr_i, `OFS_FORCE) && wb_sel_i[0] && wb_dat_i[0]
                       && (kind != timer16_pkg::KIND_FAST);
  assign forceHit[1] = writeTo(busWrite, wb_adr_i, `OFS_FORCE) && wb_sel_i[0] && wb_dat_i[1]
                       && (kind != timer16_pkg::KIND_FAST);

  always_comb begin
    if (topHit) begin
      next_counter = '0;
    end else begin
      next_counter = counter + WIDTH'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Bus slave.

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wb_dat_o <= 32'h00000000;
    end else begin
      case (wb_adr_i)
        `OFS_CONTROL: wb_dat_o <= 32'(control);
        `OFS_COUNTER: wb_dat_o <= 32'(counter);
        `OFS_COMPARE_A: wb_dat_o <= 32'(compareBuf[0]);
        `OFS_COMPARE_B: wb_dat_o <= 32'(compareBuf[1]);
        `OFS_CAPTURE: wb_dat_o <= 32'(capture);
        `OFS_FLAGS: wb_dat_o <= 32'(flags);
        default: wb_dat_o <= 32'h00000000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Control register.

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      control <= `RESET_CONTROL;
    end else if (writeTo(busWrite, wb_adr_i, `OFS_CONTROL)) begin
      if (wb_sel_i[0]) begin
        control[7:0] <= wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
        control[9:8] <= wb_dat_i[9:8];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Counter and match blocking.

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      counter <= WIDTH'(`RESET_VALUE);
    end else begin
      if (writeCounter) begin
        counter <= mergeBytes(counter, wb_dat_i, wb_sel_i);
      end else if (timerTick) begin
        counter <= next_counter;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      blockMatch <= 1'b0;
    end else begin
      if (writeCounter) begin
        blockMatch <= 1'b1;
      end else if (timerTick) begin
        blockMatch <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Compare registers and capture register.

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 2; i++) begin
        compareBuf[i] <= WIDTH'(`RESET_VALUE);
      end
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (writeCompare[i]) begin
          compareBuf[i] <= maskedCompare[i];
        end
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 2; i++) begin
        compareActive[i] <= WIDTH'(`RESET_VALUE);
      end
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (kind == timer16_pkg::KIND_FAST && topHit) begin
          compareActive[i] <= compareBuf[i];
        end else if (writeCompare[i] && kind != timer16_pkg::KIND_FAST) begin
          compareActive[i] <= maskedCompare[i];
        end
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      capture <= WIDTH'(`RESET_VALUE);
    end else if (writeTo(busWrite, wb_adr_i, `OFS_CAPTURE)) begin
      capture <= mergeBytes(capture, wb_dat_i, wb_sel_i);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Flags: hardware set wins over a write-one clear in the same cycle.

  timer16_pkg::flags_t flagSet;
  timer16_pkg::flags_t flagClear;

  always_comb begin
    flagSet = '0;
    if (kind == timer16_pkg::KIND_FAST) begin
      flagSet.overflow = topHit;
    end else begin
      flagSet.overflow = wrapMax;
    end
    flagSet.compareA = match[0] || (topHit && topIsCompareA);
    flagSet.compareB = match[1];
    flagSet.capture = topHit && topIsCapture;
  end

  always_comb begin
    flagClear = '0;
    if (writeTo(busWrite, wb_adr_i, `OFS_FLAGS) && wb_sel_i[0]) begin
      flagClear = wb_dat_i[3:0];
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      flags <= '0;
    end else begin
      flags <= (flags & ~flagClear) | flagSet;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Waveform levels.

  logic [1:0] action [2];

  assign action[0] = control.actionA;
  assign action[1] = control.actionB;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      level <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (kind == timer16_pkg::KIND_FAST) begin
          case (action[i])
            `ACTION_CLEAR: begin
              if (topHit) begin
                level[i] <= 1'b1;
              end else if (match[i]) begin
                level[i] <= 1'b0;
              end
            end
            `ACTION_SET: begin
              if (topHit) begin
                level[i] <= 1'b0;
              end else if (match[i]) begin
                level[i] <= 1'b1;
              end
            end
            `ACTION_TOGGLE: begin
              if (match[i] && i == 0 && control.mode == `MODE_FAST_A) begin
                level[i] <= !level[i];
              end
            end
            default: begin
            end
          endcase
        end else if (match[i] || forceHit[i]) begin
          case (action[i])
            `ACTION_TOGGLE: level[i] <= !level[i];
            `ACTION_CLEAR: level[i] <= 1'b0;
            `ACTION_SET: level[i] <= 1'b1;
            default: begin
            end
          endcase
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Pins.

  assign compareAPin = level[0];
  assign compareAEnable = control.dirA;
  assign compareBPin = level[1];
  assign compareBEnable = control.dirB;

endmodule : timer16_normal_ctc_fast_pwm

// [design/timer16_pkg.sv]
package timer16_pkg;

  typedef enum logic [1:0] {
    KIND_NORMAL,
    KIND_CTC,
    KIND_FAST
  } count_kind_t;

  typedef struct packed {
    logic dirB;
    logic dirA;
    logic [1:0] actionB;
    logic [1:0] actionA;
    logic [3:0] mode;
  } control_t;

  typedef struct packed {
    logic capture;
    logic compareB;
    logic compareA;
    logic overflow;
  } flags_t;

endpackage : timer16_pkg

// [test/timer16_checker_sva.sv]
`timescale 1ns/1ps
`include "timer16_cfg.svh"
module timer16_checker (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic timerTick,
  input wire logic compareAPin,
  input wire logic compareAEnable,
  input wire logic compareBPin,
  input wire logic compareBEnable
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_ack_latency: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered in one cycle");
  a_upper_zero: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:16] == 16'h0000)
    else $error("read data above bit 15 not zero");
  a_enable_a: assert property ($changed(compareAEnable) |->
    wb_ack_o && wb_we_i && wb_adr_i == `OFS_CONTROL)
    else $error("pin A enable moved without a control write");
  a_enable_b: assert property ($changed(compareBEnable) |->
    wb_ack_o && wb_we_i && wb_adr_i == `OFS_CONTROL)
    else $error("pin B enable moved without a control write");
  a_reset_quiet: assert property ($rose(rst_n) |->
    !(compareAPin || compareBPin || compareAEnable || compareBEnable))
    else $error("outputs not quiet after reset");
  a_pin_a_cause: assert property ($changed(compareAPin) |->
    $past(timerTick) || (wb_ack_o && wb_we_i))
    else $error("pin A moved without tick or write");
  a_pin_b_cause: assert property (!$past(timerTick) && !wb_ack_o |-> $stable(compareBPin))
    else $error("pin B moved without tick or write");
endmodule : timer16_checker

// [test/timer16_normal_ctc_fast_pwm_tb.sv]
`timescale 1ns/1ps
`include "timer16_cfg.svh"
module timer16_normal_ctc_fast_pwm_tb;
  logic clock;
  logic rst_n;
  logic wb_cyc_i;
  logic wb_stb_i;
  logic wb_we_i;
  logic [7:0] wb_adr_i;
  logic [31:0] wb_dat_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic timerTick;
  logic compareAPin;
  logic compareAEnable;
  logic compareBPin;
  logic compareBEnable;
  int errors;
  int checked;

  timer16_normal_ctc_fast_pwm u_timer16_normal_ctc_fast_pwm (
    .clock(clock), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .timerTick(timerTick),
    .compareAPin(compareAPin), .compareAEnable(compareAEnable),
    .compareBPin(compareBPin), .compareBEnable(compareBEnable)
  );
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      errors++;
      $display("ERROR at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clock);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clock); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask : rd

  task automatic tk(input int n);
    repeat (n) begin
      @(posedge clock);
      timerTick <= 1'b1;
    end
    @(posedge clock);
    timerTick <= 1'b0;
    @(negedge clock);
  endtask : tk

  task automatic pins(input logic [3:0] e);
    @(negedge clock);
    chk({28'h0, compareBEnable, compareAEnable, compareBPin, compareAPin}, {28'h0, e});
  endtask : pins
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rd(`OFS_COUNTER, 32'h0);
    rd(`OFS_FLAGS, 32'h0);
    pins(4'h0);
  endtask : t_reset

  task automatic t_normal();
    wr(`OFS_CONTROL, 32'h0);
    wr(`OFS_COUNTER, 32'hfffe);
    tk(2);
    rd(`OFS_COUNTER, 32'h0);
    rd(`OFS_FLAGS, 32'h1);
    wr(`OFS_FLAGS, 32'hf);
  endtask : t_normal

  task automatic t_ctc();
    wr(`OFS_COMPARE_B, 32'h8000);
    wr(`OFS_COMPARE_A, 32'h2);
    wr(`OFS_CONTROL, 32'h114);
    wr(`OFS_COUNTER, 32'h0);
    tk(3);
    rd(`OFS_COUNTER, 32'h0);
    rd(`OFS_FLAGS, 32'h2);
    pins(4'h5);
    wr(`OFS_FORCE, 32'h1);
    pins(4'h4);
    rd(`OFS_FLAGS, 32'h2);
    rd(`OFS_COUNTER, 32'h0);
    wr(`OFS_FLAGS, 32'hf);
    wr(`OFS_COUNTER, 32'hfffd);
    tk(3);
    rd(`OFS_COUNTER, 32'h0);
    rd(`OFS_FLAGS, 32'h1);
    wr(`OFS_FLAGS, 32'hf);
    wr(`OFS_COUNTER, 32'h2);
    tk(1);
    rd(`OFS_COUNTER, 32'h3);
    rd(`OFS_FLAGS, 32'h0);
    wr(`OFS_COMPARE_B, 32'h4);
    tk(2);
    rd(`OFS_FLAGS, 32'h0);
  endtask : t_ctc

  task automatic t_fast();
    wr(`OFS_CONTROL, 32'h0);
    wr(`OFS_COMPARE_A, 32'h1);
    wr(`OFS_COMPARE_B, 32'h1);
    wr(`OFS_CAPTURE, 32'h3);
    wr(`OFS_CONTROL, 32'h3ee);
    wr(`OFS_COUNTER, 32'h0);
    wr(`OFS_FLAGS, 32'hf);
    tk(2);
    pins(4'he);
    tk(2);
    pins(4'hd);
    rd(`OFS_COUNTER, 32'h0);
    rd(`OFS_FLAGS, 32'hf);
    wr(`OFS_COMPARE_A, 32'h3);
    rd(`OFS_COMPARE_A, 32'h3);
    tk(2);
    pins(4'he);
    tk(4);
    pins(4'hf);
  endtask : t_fast

  task automatic t_misc();
    wr(`OFS_CONTROL, 32'h5);
    wr(`OFS_COMPARE_B, 32'h1234);
    rd(`OFS_COMPARE_B, 32'h34);
    wr(8'h1c, 32'hffff);
    rd(8'h1c, 32'h0);
    wr(`OFS_CONTROL, 32'h200);
    pins(4'hb);
  endtask : t_misc

  task automatic results();
    $display("checked=%0d errors=%0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : results
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  initial begin
    #20000;
    errors++;
    results();
  end

  initial begin
    {rst_n, wb_cyc_i, wb_stb_i, wb_we_i, timerTick} = '0;
    wb_adr_i = 8'h00;
    wb_dat_i = 32'h0;
    wb_sel_i = 4'hf;
    errors = 0;
    checked = 0;
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    t_reset();
    t_normal();
    t_ctc();
    t_fast();
    t_misc();
    results();
  end
endmodule : timer16_normal_ctc_fast_pwm_tb

bind timer16_normal_ctc_fast_pwm timer16_checker u_timer16_checker (
  .clock(clock), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .timerTick(timerTick), .compareAPin(compareAPin), .compareAEnable(compareAEnable),
  .compareBPin(compareBPin), .compareBEnable(compareBEnable)
);
